// File: verilog/pcm_pkg.sv
// Package of constants and types for the pin control and modem mux block
package pcm_pkg;

  // ----------------------------------------------------------------
  // Geometry and clock
  // ----------------------------------------------------------------
  localparam int PCM_NPINS = 8;
  localparam int PCM_CLK_PERIOD_NS = 8;

  // ----------------------------------------------------------------
  // Register indices on the internal register port
  // ----------------------------------------------------------------
  localparam logic [3:0] PCM_ADDR_DIR = 4'h0;
  localparam logic [3:0] PCM_ADDR_STATE = 4'h1;
  localparam logic [3:0] PCM_ADDR_IEN = 4'h2;
  localparam logic [3:0] PCM_ADDR_CFG = 4'h3;

  // ----------------------------------------------------------------
  // Configuration fields and reset values
  // ----------------------------------------------------------------
  localparam int PCM_CFG_LATCH = 0;
  localparam int PCM_CFG_MODEM = 1;
  localparam int PCM_CFG_SRST = 3;
  localparam logic [7:0] PCM_DIR_RST = 8'h00;
  localparam logic [7:0] PCM_STATE_RST = 8'h00;
  localparam logic [7:0] PCM_IEN_RST = 8'h00;
  localparam logic PCM_LATCH_RST = 1'b0;
  localparam logic PCM_MODEM_RST = 1'b0;
  localparam logic [7:0] PCM_ZERO8 = 8'h00;

  // ----------------------------------------------------------------
  // Pins taken over in modem role
  // ----------------------------------------------------------------
  localparam int PCM_PIN_DSR = 4;
  localparam int PCM_PIN_DTR = 5;
  localparam int PCM_PIN_CD = 6;
  localparam int PCM_PIN_RI = 7;
  localparam logic [7:0] PCM_MODEM_MASK = 8'hf0;
  localparam logic [2:0] PCM_MODEM_IDLE = 3'h7;

  // ----------------------------------------------------------------
  // Soft reset timing
  // ----------------------------------------------------------------
  localparam int PCM_SRST_TIME_NS = 40;
  localparam int PCM_SRST_CYC =
    (PCM_SRST_TIME_NS + PCM_CLK_PERIOD_NS - 1) / PCM_CLK_PERIOD_NS;
  localparam logic [3:0] PCM_SRST_LOAD = 4'(PCM_SRST_CYC - 1);

  typedef enum logic [1:0] {
    PCM_SR_IDLE = 2'b00,
    PCM_SR_HOLD = 2'b01,
    PCM_SR_DONE = 2'b11
  } pcm_srst_e;

endpackage : pcm_pkg

// File: verilog/pcm_chg_if.sv
// Interface between the pin control core and the change detector
interface pcm_chg_if #(parameter int N = 8);
  logic [N-1:0] pinLvl;
  logic [N-1:0] armMask;
  logic [N-1:0] pending;
  logic [N-1:0] latchVal;
  logic latchEn;
  logic stateRead;
  logic clearAll;

  modport ctrl (
    output pinLvl, armMask, latchEn, stateRead, clearAll,
    input pending, latchVal
  );
  modport det (
    input pinLvl, armMask, latchEn, stateRead, clearAll,
    output pending, latchVal
  );
endinterface : pcm_chg_if

// File: verilog/pcm_change_detect.sv
// Per-pin input change detector with optional value latching
module pcm_change_detect #(
  parameter int N = 8
) (
  input wire logic clk,
  input wire logic rstSync_b,
  pcm_chg_if.det chg
);

  logic [N-1:0] ref_q;
  logic [N-1:0] ref_d;
  logic [N-1:0] pend_q;
  logic [N-1:0] pend_d;
  logic [N-1:0] lat_q;
  logic [N-1:0] lat_d;
  logic [N-1:0] last_q;
  logic [N-1:0] last_d;

  // ----------------------------------------------------------------
  // One slice per pin
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : gSlice
      // Next state of one pin's reference, pending flag and latch
      always_comb begin
        ref_d[i] = ref_q[i];
        pend_d[i] = pend_q[i];
        lat_d[i] = chg.pinLvl[i];
        last_d[i] = chg.pinLvl[i];
        if (chg.clearAll || !chg.armMask[i]) begin
          // Unarmed pins track the pin so arming never fires at once
          ref_d[i] = chg.pinLvl[i];
          pend_d[i] = 1'b0;
        end else if (!chg.latchEn) begin
          pend_d[i] = !chg.stateRead && (chg.pinLvl[i] != ref_q[i]);
          if (chg.stateRead) begin
            ref_d[i] = chg.pinLvl[i];
          end
        end else if (!pend_q[i]) begin
          pend_d[i] = chg.pinLvl[i] != ref_q[i];
        end else begin
          lat_d[i] = lat_q[i];
          if (chg.stateRead) begin
            // latched read clears pending
            // Only a change at this very edge re-pends; an earlier return does not
            ref_d[i] = last_q[i];
            pend_d[i] = chg.pinLvl[i] != last_q[i];
            lat_d[i] = chg.pinLvl[i];
          end
        end
      end
    end
  endgenerate

  // Register the detector state
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      ref_q <= '0;
      pend_q <= '0;
      lat_q <= '0;
      last_q <= '0;
    end else begin
      ref_q <= ref_d;
      pend_q <= pend_d;
      lat_q <= lat_d;
      last_q <= last_d;
    end
  end

  assign chg.pending = pend_q;
  assign chg.latchVal = lat_q;

endmodule : pcm_change_detect

// File: verilog/pcm_pin_ctrl.sv
// Pin configuration, general-purpose pin control and modem pin mux
//
// What this block does
// - Writing one to configuration bit 3 starts a full software reset.
// - The reset bit clears itself once the software reset completes.
// - Configuration bit 1 gives pins 7:4 general-purpose or modem role.
// - Unlatched: any input change raises interrupt; state read clears it.
// - Unlatched: input returning to original level before read withdraws interrupt.
// - Latched: change raises interrupt and captures new level in state bit.
// - Latched: reading the pin state register clears the interrupt.
// - Latched: interrupt and captured level hold until the state read.
// - General role: CD, RI, DSR levels hidden from modem status.
// - General role: CD, RI, DSR changes never raise modem interrupt.
// - General role: modem control DTR bit does not reach the pin.
// - Modem role: CD, RI, DSR levels shown to modem status.
// - Modem role: DTR pin follows the modem control DTR bit.
// - Modem role: enabled modem interrupt fires on RI, CD, DSR change.
// - Modem role: upper direction, state, enable bits ignore the modem pins.
// - General role: pins 7:4 follow direction, state, enable, config.
// - Only input pins with interrupt enable set raise change interrupts.
// - State read returns pin levels; write drives output pins.
module pcm_pin_ctrl
  import pcm_pkg::*;
#(
  parameter int N = PCM_NPINS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] regAddr,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  input wire logic [N-1:0] pinIn,
  output logic [N-1:0] pinOut,
  output logic [N-1:0] pinOe_b,
  input wire logic mcrDtr,
  input wire logic ierModemEn,
  output logic [2:0] modemLevels,
  output logic modemChange,
  output logic pinIrq,
  output logic devSoftReset
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------

  // Pins left under general-purpose control in the given role
  function automatic logic [N-1:0] gpioOwned(input logic modem);
    gpioOwned = modem ? N'(~PCM_MODEM_MASK) : {N{1'b1}};
  endfunction : gpioOwned

  // One register access hit on a given index
  function automatic logic hit(
    input logic en,
    input logic [3:0] addr,
    input logic [3:0] target
  );
    hit = en && (addr == target);
  endfunction : hit

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rstMeta_q;
  logic rstSync_q;

  // Two flops so release never lands near a clock edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  pcm_srst_e srState_q;
  pcm_srst_e srState_d;
  logic [3:0] srCnt_q;
  logic [3:0] srCnt_d;
  logic [N-1:0] dir_q;
  logic [N-1:0] dir_d;
  logic [N-1:0] state_q;
  logic [N-1:0] state_d;
  logic [N-1:0] ien_q;
  logic [N-1:0] ien_d;
  logic latch_q;
  logic latch_d;
  logic modem_q;
  logic modem_d;
  logic srHold;
  logic wrDir;
  logic wrState;
  logic wrIen;
  logic wrCfg;
  logic rdState;
  logic [N-1:0] stateView;
  logic [7:0] rdData_d;
  logic [7:0] regRdData_q;
  logic [N-1:0] pinOut_d;
  logic [N-1:0] pinOut_q;
  logic [N-1:0] pinOe_d;
  logic [N-1:0] pinOe_q;
  logic [2:0] modemLvl_d;
  logic [2:0] modemLvl_q;
  logic modemChg_d;
  logic modemChg_q;
  logic pinIrq_d;
  logic pinIrq_q;
  logic devRst_d;
  logic devRst_q;

  pcm_chg_if #(.N(N)) chg ();

  // ----------------------------------------------------------------
  // Access strobes
  // ----------------------------------------------------------------

  // Writes are refused while the software reset is in progress
  always_comb begin
    srHold = srState_q == PCM_SR_HOLD;
    wrDir = hit(regWrEn, regAddr, PCM_ADDR_DIR) && !srHold;
    wrState = hit(regWrEn, regAddr, PCM_ADDR_STATE) && !srHold;
    wrIen = hit(regWrEn, regAddr, PCM_ADDR_IEN) && !srHold;
    wrCfg = hit(regWrEn, regAddr, PCM_ADDR_CFG) && !srHold;
    rdState = hit(regRdEn, regAddr, PCM_ADDR_STATE);
  end

  // ----------------------------------------------------------------
  // Software reset sequencer
  // ----------------------------------------------------------------

  // Next state of the reset sequence and its hold counter
  always_comb begin
    srState_d = srState_q;
    srCnt_d = srCnt_q;
    unique case (srState_q)
      PCM_SR_IDLE: begin
        if (wrCfg && regWrData[PCM_CFG_SRST]) begin
          srState_d = PCM_SR_HOLD;
          srCnt_d = PCM_SRST_LOAD;
        end
      end
      PCM_SR_HOLD: begin
        if (srCnt_q == 4'h0) begin
          srState_d = PCM_SR_DONE;
        end else begin
          srCnt_d = srCnt_q - 4'h1;
        end
      end
      PCM_SR_DONE: begin
        srState_d = PCM_SR_IDLE;
      end
      default: begin
        srState_d = PCM_SR_IDLE;
      end
    endcase
  end

  // Register the reset sequence
  always_ff @(posedge clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      srState_q <= PCM_SR_IDLE;
      srCnt_q <= 4'h0;
    end else begin
      srState_q <= srState_d;
      srCnt_q <= srCnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------

  // Register writes; the software reset returns everything to defaults
  always_comb begin
    dir_d = dir_q;
    state_d = state_q;
    ien_d = ien_q;
    latch_d = latch_q;
    modem_d = modem_q;
    if (srHold) begin
      dir_d = PCM_DIR_RST;
      state_d = PCM_STATE_RST;
      ien_d = PCM_IEN_RST;
      latch_d = PCM_LATCH_RST;
      modem_d = PCM_MODEM_RST;
    end else begin
      if (wrDir) begin
        dir_d = regWrData[N-1:0];
      end
      if (wrState) begin
        state_d = regWrData[N-1:0];
      end
      if (wrIen) begin
        ien_d = regWrData[N-1:0];
      end
      if (wrCfg) begin
        modem_d = regWrData[PCM_CFG_MODEM];
        latch_d = regWrData[PCM_CFG_LATCH];
      end
    end
  end

  // Register the configuration
  always_ff @(posedge clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      dir_q <= PCM_DIR_RST;
      state_q <= PCM_STATE_RST;
      ien_q <= PCM_IEN_RST;
      latch_q <= PCM_LATCH_RST;
      modem_q <= PCM_MODEM_RST;
    end else begin
      dir_q <= dir_d;
      state_q <= state_d;
      ien_q <= ien_d;
      latch_q <= latch_d;
      modem_q <= modem_d;
    end
  end

  // ----------------------------------------------------------------
  // Change detector hookup
  // ----------------------------------------------------------------

  // Arm only enabled inputs still under general-purpose control
  always_comb begin
    chg.pinLvl = pinIn;
    chg.armMask = ~dir_q & ien_q & gpioOwned(modem_q);
    chg.latchEn = latch_q;
    chg.stateRead = rdState;
    // A direction write drops any pending change, as does soft reset
    chg.clearAll = wrDir || srHold;
  end

  pcm_change_detect #(.N(N)) uDetect (
    .clk(clk),
    .rstSync_b(rstSync_q),
    .chg(chg)
  );

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------

  // Latched pending bits show the captured level, others the live pin
  always_comb begin
    stateView = (chg.pending & {N{latch_q}} & chg.latchVal)
      | (~(chg.pending & {N{latch_q}}) & pinIn);
    rdData_d = regRdData_q;
    if (regRdEn) begin
      rdData_d = PCM_ZERO8;
      unique case (regAddr)
        PCM_ADDR_DIR: rdData_d[N-1:0] = dir_q;
        PCM_ADDR_STATE: rdData_d[N-1:0] = stateView;
        PCM_ADDR_IEN: rdData_d[N-1:0] = ien_q;
        PCM_ADDR_CFG: begin
          rdData_d[PCM_CFG_LATCH] = latch_q;
          rdData_d[PCM_CFG_MODEM] = modem_q;
          rdData_d[PCM_CFG_SRST] = srState_q != PCM_SR_IDLE;
        end
        default: rdData_d = PCM_ZERO8;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drive and modem mux
  // ----------------------------------------------------------------

  // Drive outputs from the state register or from the modem logic
  always_comb begin
    pinOut_d = state_q;
    pinOe_d = ~dir_q;
    if (modem_q) begin
      pinOut_d[7:4] = 4'h0;
      pinOe_d[7:4] = 4'hf;
      // DTR follows control bit, active low at the pin
      pinOut_d[PCM_PIN_DTR] = !mcrDtr;
      pinOe_d[PCM_PIN_DTR] = 1'b0;
    end
    // general role DTR untouched by the control bit
    modemLvl_d = modem_q ? {pinIn[PCM_PIN_CD], pinIn[PCM_PIN_RI],
      pinIn[PCM_PIN_DSR]} : PCM_MODEM_IDLE;
    // never in general role
    // Entering modem role can show one change if pins sit low
    modemChg_d = modem_q && ierModemEn && (modemLvl_d != modemLvl_q);
    pinIrq_d = |chg.pending;
    devRst_d = srHold;
  end

  // Every output leaves from a flop
  always_ff @(posedge clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      regRdData_q <= PCM_ZERO8;
      pinOut_q <= '0;
      pinOe_q <= '1;
      modemLvl_q <= PCM_MODEM_IDLE;
      modemChg_q <= 1'b0;
      pinIrq_q <= 1'b0;
      devRst_q <= 1'b0;
    end else begin
      regRdData_q <= rdData_d;
      pinOut_q <= pinOut_d;
      pinOe_q <= pinOe_d;
      modemLvl_q <= modemLvl_d;
      modemChg_q <= modemChg_d;
      pinIrq_q <= pinIrq_d;
      devRst_q <= devRst_d;
    end
  end

  assign regRdData = regRdData_q;
  assign pinOut = pinOut_q;
  assign pinOe_b = pinOe_q;
  assign modemLevels = modemLvl_q;
  assign modemChange = modemChg_q;
  assign pinIrq = pinIrq_q;
  assign devSoftReset = devRst_q;

endmodule : pcm_pin_ctrl

// File: tb/pcm_pin_ctrl_assertions.sv
// Port-level concurrent checks for the pin control block
module pcm_pin_ctrl_assertions
  import pcm_pkg::*;
#(
  parameter int N = PCM_NPINS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] regAddr,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regWrData,
  input wire logic [N-1:0] pinIn,
  input wire logic [N-1:0] pinOut,
  input wire logic [N-1:0] pinOe_b,
  input wire logic mcrDtr,
  input wire logic ierModemEn,
  input wire logic [2:0] modemLevels,
  input wire logic modemChange,
  input wire logic pinIrq,
  input wire logic devSoftReset
);
  // ------
  // Role tracking
  // ------
  logic modemRole_q;
  logic [2:0] modemPins;
  assign modemPins = {pinIn[PCM_PIN_CD], pinIn[PCM_PIN_RI], pinIn[PCM_PIN_DSR]};

  // Soft reset drops the role too, so stale modem checks cannot fire
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      modemRole_q <= 1'b0;
    end else if (devSoftReset) begin
      modemRole_q <= 1'b0;
    end else if (regWrEn && regAddr == PCM_ADDR_CFG) begin
      modemRole_q <= regWrData[PCM_CFG_MODEM];
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // Three cycles of settled role cover the two-cycle output lag
  sequence sPinRole;
    !modemRole_q [*3];
  endsequence
  sequence sModemRole;
    modemRole_q [*3];
  endsequence
  sequence sSrstWr;
    regWrEn && regAddr == PCM_ADDR_CFG && regWrData[PCM_CFG_SRST] && !devSoftReset;
  endsequence

  AST_SRST_PULSE: assert property (sSrstWr |=> ##1 devSoftReset [*5] ##1 !devSoftReset)
    else $error("soft reset hold is not five cycles");
  AST_SRST_CLEAN: assert property ($fell(devSoftReset) |-> pinOe_b == '1 && !pinIrq)
    else $error("pins or interrupt not cleared by soft reset");
  AST_PIN_HIDE: assert property (sPinRole |-> modemLevels == PCM_MODEM_IDLE)
    else $error("modem levels visible in pin role");
  AST_PIN_NO_MODEM_IRQ: assert property (sPinRole |-> !modemChange)
    else $error("modem change raised in pin role");
  AST_PIN_DTR_FREE: assert property (sPinRole ##0 ($changed(mcrDtr) && !regWrEn)
    |=> $stable(pinOut[PCM_PIN_DTR]) [*2]) else $error("dtr bit reached the pin in pin role");
  AST_MODEM_LEVELS: assert property (sModemRole |-> modemLevels == $past(modemPins))
    else $error("modem levels do not follow the pins");
  AST_MODEM_DTR: assert property (sModemRole ##0 (mcrDtr == $past(mcrDtr)
    && mcrDtr == $past(mcrDtr, 2)) |-> !pinOe_b[PCM_PIN_DTR] && pinOut[PCM_PIN_DTR] == !mcrDtr)
    else $error("dtr pin does not follow the control bit");
  AST_MODEM_CHANGE: assert property (sModemRole ##0 (ierModemEn
    && modemPins != $past(modemPins)) |=> modemChange) else $error("modem change missed");
  AST_READ_CLEARS: assert property ($stable(pinIn) [*3] ##0 (regRdEn
    && regAddr == PCM_ADDR_STATE) |=> $stable(pinIn) ##1 !pinIrq)
    else $error("state read did not clear the interrupt");
endmodule : pcm_pin_ctrl_assertions

bind pcm_pin_ctrl pcm_pin_ctrl_assertions #(.N(N)) u_pcm_pin_ctrl_assertions (
  .clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn),
  .regWrData(regWrData), .pinIn(pinIn), .pinOut(pinOut), .pinOe_b(pinOe_b),
  .mcrDtr(mcrDtr), .ierModemEn(ierModemEn), .modemLevels(modemLevels),
  .modemChange(modemChange), .pinIrq(pinIrq), .devSoftReset(devSoftReset)
);

// File: tb/pcm_pin_model.sv
// Behavioural model of the equipment wired to the eight pins
module pcm_pin_model #(
  parameter int N = 8
) (
  input wire logic [N-1:0] pinOut,
  input wire logic [N-1:0] pinOe_b,
  input wire logic [N-1:0] extLvl,
  output logic [N-1:0] pinIn
);
  timeunit 1ns;
  timeprecision 1ps;
  // Device wins where it drives; elsewhere the far side sets the level
  always_comb begin
    for (int i = 0; i < N; i++) begin
      pinIn[i] = pinOe_b[i] ? extLvl[i] : pinOut[i];
    end
  end
endmodule : pcm_pin_model

// File: tb/pcm_pin_ctrl_tb.sv
// Self-checking bench for the pin control and modem mux block
module pcm_pin_ctrl_tb
  import pcm_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  // ------
  // Signals and instances
  // ------
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [7:0] regWrData = 8'h00;
  logic mcrDtr = 1'b0;
  logic ierModemEn = 1'b0;
  logic [7:0] extLvl = 8'h00;
  logic [7:0] pinIn, regRdData, pinOut, pinOe_b;
  logic [2:0] modemLevels;
  logic modemChange, pinIrq, devSoftReset;
  int errors = 0;
  int check_count = 0;
  int chgCnt = 0;
  int base = 0;

  always #4 clk = ~clk;
  // The change flag is a one-cycle pulse, so count it rather than poll
  always @(posedge clk) if (modemChange === 1'b1) chgCnt++;

  pcm_pin_ctrl u_pcm_pin_ctrl (.clk(clk), .rst_b(rst_b), .regAddr(regAddr),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe_b(pinOe_b), .mcrDtr(mcrDtr),
    .ierModemEn(ierModemEn), .modemLevels(modemLevels), .modemChange(modemChange),
    .pinIrq(pinIrq), .devSoftReset(devSoftReset));
  pcm_pin_model u_pcm_pin_model (.pinOut(pinOut), .pinOe_b(pinOe_b), .extLvl(extLvl),
    .pinIn(pinIn));

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp, input string name);
    @(posedge clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    @(negedge clk);
    chk(name, exp, regRdData);
  endtask : rdc
  task automatic tgl(input int i);
    @(posedge clk);
    extLvl[i] <= ~extLvl[i];
  endtask : tgl
  // Irq needs two edges after a pin change; three leaves a margin
  task automatic waitIrq(input logic e);
    cyc(3);
    @(negedge clk);
    chk("pinIrq", 8'(e), 8'(pinIrq));
  endtask : waitIrq
  task automatic settle(input int n);
    cyc(n);
    @(negedge clk);
  endtask : settle
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  // ------
  // Tests
  // ------
  initial begin
    cyc(3);
    rst_b <= 1'b1;
    cyc(3);
    rdc(PCM_ADDR_DIR, PCM_DIR_RST, "dir");
    rdc(PCM_ADDR_IEN, PCM_IEN_RST, "ien");
    rdc(PCM_ADDR_CFG, 8'h00, "cfg");
    wr(4'h9, 8'hff);
    rdc(4'h9, 8'h00, "unmapped");
    rdc(PCM_ADDR_DIR, PCM_DIR_RST, "dir");
    chk("oe", 8'hff, pinOe_b);
    // Upper pins as outputs, lower pins read back from the far side
    wr(PCM_ADDR_DIR, 8'hf0);
    wr(PCM_ADDR_STATE, 8'ha5);
    extLvl <= 8'h03;
    settle(2);
    chk("oe", 8'h0f, pinOe_b);
    chk("out", 8'ha0, pinOut & 8'hf0);
    rdc(PCM_ADDR_STATE, 8'ha3, "state");
    // Unlatched change interrupts
    wr(PCM_ADDR_DIR, 8'h00);
    wr(PCM_ADDR_IEN, 8'h01);
    tgl(1); waitIrq(1'b0);
    tgl(0); waitIrq(1'b1);
    tgl(0); waitIrq(1'b0);
    tgl(0); waitIrq(1'b1);
    rdc(PCM_ADDR_STATE, 8'h00, "state");
    waitIrq(1'b0);
    // Latched change interrupts; captured level read back before the live one
    wr(PCM_ADDR_CFG, 8'h01);
    tgl(0); waitIrq(1'b1);
    tgl(0); waitIrq(1'b1);
    rdc(PCM_ADDR_STATE, 8'h01, "latched");
    waitIrq(1'b0);
    rdc(PCM_ADDR_STATE, 8'h00, "live");
    // Modem role
    wr(PCM_ADDR_CFG, 8'h02);
    extLvl <= 8'h50;
    ierModemEn <= 1'b1;
    mcrDtr <= 1'b1;
    settle(4);
    chk("dtr", 8'h00, 8'({pinOe_b[5], pinOut[5]}));
    chk("levels", 8'h05, 8'(modemLevels));
    base = chgCnt;
    tgl(7); settle(3);
    chk("modemChange", 8'h01, 8'(chgCnt - base));
    wr(PCM_ADDR_DIR, 8'hff);
    wr(PCM_ADDR_STATE, 8'h00);
    wr(PCM_ADDR_IEN, 8'hf0);
    mcrDtr <= 1'b0;
    tgl(6); settle(3);
    chk("oe", 8'hd0, pinOe_b & 8'hf0);
    chk("dtr", 8'h01, 8'({pinOe_b[5], pinOut[5]}));
    chk("pinIrq", 8'h00, 8'(pinIrq));
    base = chgCnt;
    tgl(4);
    ierModemEn <= 1'b0;
    settle(3);
    chk("modemChange", 8'h00, 8'(chgCnt - base));
    // Back to pin role: modem paths must go quiet
    wr(PCM_ADDR_DIR, 8'h00);
    wr(PCM_ADDR_IEN, 8'h00);
    wr(PCM_ADDR_CFG, 8'h00);
    ierModemEn <= 1'b1;
    settle(4);
    chk("levels", 8'h07, 8'(modemLevels));
    base = chgCnt;
    tgl(6);
    mcrDtr <= 1'b1;
    settle(3);
    chk("modemChange", 8'h00, 8'(chgCnt - base));
    chk("dtr", 8'h02, 8'({pinOe_b[5], pinOut[5]}));
    // Soft reset, with a write that lands during the hold
    wr(PCM_ADDR_DIR, 8'h0f);
    wr(PCM_ADDR_CFG, 8'h08);
    wr(PCM_ADDR_DIR, 8'hff);
    settle(10);
    rdc(PCM_ADDR_CFG, 8'h00, "cfg");
    rdc(PCM_ADDR_DIR, PCM_DIR_RST, "dir");
    chk("oe", 8'hff, pinOe_b);
    end_of_test();
  end

  // Watchdog: the tests take under two hundred cycles
  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    $display("BAD watchdog expected finish seen hang");
    end_of_test();
  end
endmodule : pcm_pin_ctrl_tb
